// file: ctcr_map.vh
// Register offsets, field positions, reset values and mode codes of the transceiver control bank.
`ifndef CTCR_MAP_VH
`define CTCR_MAP_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define CTCR_ADDR_W          3
`define CTCR_OFS_PORT_DATA   3'h0
`define CTCR_OFS_PHY_CTRL    3'h1
`define CTCR_OFS_TEST_A      3'h2
`define CTCR_OFS_BUS_STATUS  3'h3
`define CTCR_OFS_TEST_B      3'h4
`define CTCR_OFS_TEST_C      3'h5
`define CTCR_OFS_IRQ_ENABLE  3'h6
`define CTCR_OFS_IRQ_FLAGS   3'h7

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CTCR_PD_WAKE_BIT     7
`define CTCR_PD_TX_BIT       1
`define CTCR_PD_RX_BIT       0
`define CTCR_PC_EN_BIT       7
`define CTCR_PC_SPLIT_BIT    6
`define CTCR_PC_WUP_HI       5
`define CTCR_PC_WUP_LO       4
`define CTCR_PC_SLEW_HI      2
`define CTCR_PC_SLEW_LO      0
`define CTCR_IE_VF_BIT       4
`define CTCR_IE_DT_BIT       3
`define CTCR_IE_OC_BIT       0
`define CTCR_ST_FIRST_BIT    3
`define CTCR_IF_OC_HI        1

// ----------------------------------------------------------------------------
// Implemented bit masks and reset values
// ----------------------------------------------------------------------------
`define CTCR_STATUS_MASK     8'hF8
`define CTCR_ENABLE_MASK     8'h19
`define CTCR_FLAGS_MASK      8'hFB
`define CTCR_ZERO8           8'h00
`define CTCR_RST_WUP         2'h2
`define CTCR_RST_SLEW        3'h0
`define CTCR_RST_TEST        8'h00
`define CTCR_RECESSIVE       1'b1
`define CTCR_DOMINANT        1'b0

// ----------------------------------------------------------------------------
// Wake-up select codes, reserved slew codes and modes
// ----------------------------------------------------------------------------
`define CTCR_WUP_OFF         2'h0
`define CTCR_WUP_MASK1       2'h1
`define CTCR_WUP_PLAIN       2'h2
`define CTCR_WUP_MASK2       2'h3
`define CTCR_SLEW_RSVD_A     3'h3
`define CTCR_SLEW_RSVD_B     3'h7
`define CTCR_MODE_SHUTDOWN   2'h0
`define CTCR_MODE_NORMAL     2'h1
`define CTCR_MODE_STANDBY    2'h2
`define CTCR_CNT_ONE         2'h1
`define CTCR_CNT_TWO         2'h2

`endif

// file: ctcr_wake_filter.v
// Dominant pulse filter that hides the first one or two wake-up events.
`timescale 1ns/1ns
`default_nettype none
`include "ctcr_map.vh"

module ctcr_wake_filter (
  input  wire       core_clk_in,  // Core clock.
  input  wire       rst_n_in,     // Asynchronous reset, active low.
  input  wire       arm_in,       // Filter active while high.
  input  wire [1:0] mask_cnt_in,  // Number of events to hide.
  input  wire       wake_rx_in,   // Wake-up receiver level, 0 = dominant.
  output reg        wake_out      // Filtered level.
);

  reg  [1:0] seen_q;     // Completed dominant events counted so far.
  reg        prev_q;     // Previous wake-up level.
  wire       pulse_end;  // Dominant to recessive edge ends one event.

  assign pulse_end = (prev_q == `CTCR_DOMINANT) && (wake_rx_in == `CTCR_RECESSIVE);

  // ----------------------------------------------------------------------------
  // Event counting and output masking
  // ----------------------------------------------------------------------------
  // Counter restarts whenever the filter is disarmed, so each stop entry masks afresh.
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      seen_q   <= 2'h0;
      prev_q   <= `CTCR_RECESSIVE;
      wake_out <= `CTCR_RECESSIVE;
    end else begin
      prev_q <= wake_rx_in;
      if (!arm_in) begin
        seen_q   <= 2'h0;
        wake_out <= wake_rx_in;
      end else begin
        if (pulse_end && (seen_q < mask_cnt_in)) begin
          seen_q <= seen_q + 2'h1;
        end
        // Masked events are shown recessive to keep false wake-ups away.
        wake_out <= (seen_q < mask_cnt_in) ? `CTCR_RECESSIVE : wake_rx_in;
      end
    end
  end

endmodule // ctcr_wake_filter

`default_nettype wire

// file: ctcr_regs.v
// Control and observation logic of the on-chip high-speed CAN transceiver.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ns
`include "ctcr_map.vh"
`default_nettype none

module ctcr_regs (
  input  wire       core_clk_in,              // Core clock, 125 MHz.
  input  wire       rst_n_in,                 // Asynchronous reset, active low.
  input  wire [2:0] addr_in,                  // Register offset.
  input  wire [7:0] wdata_in,                 // Write data.
  input  wire       wr_in,                    // Write strobe, one cycle.
  input  wire       rd_in,                    // Read strobe, one cycle.
  output reg  [7:0] rdata_out,                // Read data, cycle after strobe.
  input  wire       controller_tx_output_in,  // Controller transmit level.
  input  wire       tx_route_reg_in,          // High: transmit driven by port data.
  input  wire       precision_rx_in,          // Precision receiver level.
  input  wire       wakeup_rx_in,             // Wake-up receiver level.
  input  wire       stop_req_in,              // Processor stop requested.
  input  wire       reg_rpm_in,               // Regulator in reduced performance.
  input  wire       special_mode_in,          // Chip in special mode.
  input  wire [4:0] bus_status_in,            // Voltage and timeout monitors.
  input  wire [1:0] over_current_in,          // Over-current events, high side first.
  output reg        phy_tx_input_out,         // Transmit input of the driver.
  output reg        tx_dominant_out,          // Driver pulls the bus dominant.
  output reg        phy_rx_output_out,        // Receive level to the controller.
  output reg  [1:0] mode_out,                 // Operating mode.
  output reg        split_bias_en_out,        // Split pin drives bias.
  output reg        wakeup_rx_en_out,         // Wake-up receiver powered.
  output reg  [2:0] slew_rate_out,            // Selected slew rate.
  output reg  [7:0] test_a_out,               // Factory-test register A.
  output reg  [7:0] test_b_out,               // Factory-test register B.
  output reg  [7:0] test_c_out,               // Factory-test register C.
  output reg        irq_out                   // Fault interrupt, level.
);

  // ----------------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------------
  reg        tx_drive_bit_q;         // Port data bit 1.
  reg        rx_readback_q;          // Synchronized receive output.
  reg        wakeup_rx_readback_q;   // Synchronized wake-up receiver level.
  reg        phy_enable_once_q;      // Set-once enable.
  reg        split_bias_enable_q;    // Split enable.
  reg  [1:0] wakeup_filter_select_q; // Wake-up select.
  reg  [2:0] slew_rate_select_q;     // Slew-rate select.
  reg  [4:0] status_q;               // Monitor levels.
  reg  [4:0] status_prev_q;          // Monitor levels one cycle back.
  reg        status_seen_q;          // First monitor sample taken.
  reg  [7:0] irq_enable_q;           // Interrupt enable register.
  reg  [7:0] irq_flags_q;            // Sticky flags.
  reg  [7:0] irq_flags_d;            // Next flags.
  reg  [1:0] mode_d;                 // Next mode.
  reg  [1:0] mask_cnt;               // Events to hide.
  reg        rx_d;                   // Next receive level.
  reg  [7:0] rdata_d;                // Next read data.
  reg  [7:0] set_vec;                // Flag set events.
  reg  [7:0] clr_vec;                // Flag clear requests.
  reg  [7:0] en_vec;                 // Enables spread to flag layout.
  wire       filt_wake;              // Filtered wake-up level.
  wire       filt_arm;               // Filter armed.
  wire       wr_pd;                  // Port data write.
  wire       wr_pc;                  // Control write.
  wire       wr_ie;                  // Enable write.
  wire       wr_if;                  // Flag write.
  wire       tx_level;               // Level feeding the driver.

  // Decodes a write strobe for one offset.
  function wr_hit;
    input [2:0] a;
    input [2:0] ofs;
    input       w;
    begin
      wr_hit = w && (a == ofs);
    end
  endfunction

  // Tells whether a slew code is one of the reserved pair.
  function slew_rsvd;
    input [2:0] code;
    begin
      slew_rsvd = (code == `CTCR_SLEW_RSVD_A) || (code == `CTCR_SLEW_RSVD_B);
    end
  endfunction

  assign wr_pd = wr_hit(addr_in, `CTCR_OFS_PORT_DATA, wr_in);
  assign wr_pc = wr_hit(addr_in, `CTCR_OFS_PHY_CTRL, wr_in);
  assign wr_ie = wr_hit(addr_in, `CTCR_OFS_IRQ_ENABLE, wr_in);
  assign wr_if = wr_hit(addr_in, `CTCR_OFS_IRQ_FLAGS, wr_in);

  // ----------------------------------------------------------------------------
  // Port data and control registers
  // ----------------------------------------------------------------------------
  // Enable can only be raised, so a stray write cannot drop the transceiver to shutdown.
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_drive_bit_q         <= `CTCR_RECESSIVE;
      phy_enable_once_q      <= 1'b0;
      split_bias_enable_q    <= 1'b0;
      wakeup_filter_select_q <= `CTCR_RST_WUP;
      slew_rate_select_q     <= `CTCR_RST_SLEW;
    end else begin
      if (wr_pd) begin
        tx_drive_bit_q <= wdata_in[`CTCR_PD_TX_BIT];
      end
      if (wr_pc) begin
        phy_enable_once_q      <= phy_enable_once_q | wdata_in[`CTCR_PC_EN_BIT];
        split_bias_enable_q    <= wdata_in[`CTCR_PC_SPLIT_BIT];
        wakeup_filter_select_q <= wdata_in[`CTCR_PC_WUP_HI:`CTCR_PC_WUP_LO];
        // A reserved slew code leaves the previous rate in place.
        if (!slew_rsvd(wdata_in[`CTCR_PC_SLEW_HI:`CTCR_PC_SLEW_LO])) begin
          slew_rate_select_q <= wdata_in[`CTCR_PC_SLEW_HI:`CTCR_PC_SLEW_LO];
        end
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Factory-test registers
  // ----------------------------------------------------------------------------
  // Writes outside special mode are dropped silently.
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      test_a_out <= `CTCR_RST_TEST;
      test_b_out <= `CTCR_RST_TEST;
      test_c_out <= `CTCR_RST_TEST;
    end else if (special_mode_in) begin
      if (wr_hit(addr_in, `CTCR_OFS_TEST_A, wr_in)) begin
        test_a_out <= wdata_in;
      end
      if (wr_hit(addr_in, `CTCR_OFS_TEST_B, wr_in)) begin
        test_b_out <= wdata_in;
      end
      if (wr_hit(addr_in, `CTCR_OFS_TEST_C, wr_in)) begin
        test_c_out <= wdata_in;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Mode selection
  // ----------------------------------------------------------------------------
  // Shutdown has priority; standby follows the regulator, not the stop request.
  always @* begin
    case ({phy_enable_once_q, reg_rpm_in})
      2'b10:   mode_d = `CTCR_MODE_NORMAL;
      2'b11:   mode_d = `CTCR_MODE_STANDBY;
      default: mode_d = `CTCR_MODE_SHUTDOWN;
    endcase
  end

  // Filter depth from wake-up select.
  always @* begin
    case (wakeup_filter_select_q)
      `CTCR_WUP_MASK1: mask_cnt = `CTCR_CNT_ONE;
      `CTCR_WUP_MASK2: mask_cnt = `CTCR_CNT_TWO;
      default:         mask_cnt = 2'h0;
    endcase
  end

  // Arms at the stop request itself, ahead of the regulator switch.
  assign filt_arm = stop_req_in && (mask_cnt != 2'h0);

  ctcr_wake_filter u_wake_filter (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .arm_in      (filt_arm),
    .mask_cnt_in (mask_cnt),
    .wake_rx_in  (wakeup_rx_in),
    .wake_out    (filt_wake)
  );

  // ----------------------------------------------------------------------------
  // Receive and transmit paths
  // ----------------------------------------------------------------------------
  // Receive source switches with the mode; shutdown shows recessive.
  always @* begin
    case (mode_d)
      `CTCR_MODE_STANDBY: rx_d = filt_wake;
      `CTCR_MODE_NORMAL:  rx_d = precision_rx_in;
      default:            rx_d = `CTCR_RECESSIVE;
    endcase
  end

  // The routing choice is made outside this bank, so it arrives as a plain level.
  assign tx_level = tx_route_reg_in ? tx_drive_bit_q : controller_tx_output_in;

  // Outputs and readbacks; the driver only pulls dominant in normal mode.
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phy_tx_input_out     <= `CTCR_RECESSIVE;
      tx_dominant_out      <= 1'b0;
      phy_rx_output_out    <= `CTCR_RECESSIVE;
      rx_readback_q        <= `CTCR_RECESSIVE;
      wakeup_rx_readback_q <= `CTCR_RECESSIVE;
      mode_out             <= `CTCR_MODE_SHUTDOWN;
      split_bias_en_out    <= 1'b0;
      wakeup_rx_en_out     <= 1'b0;
      slew_rate_out        <= `CTCR_RST_SLEW;
    end else begin
      phy_tx_input_out     <= tx_level;
      tx_dominant_out      <= (tx_level == `CTCR_DOMINANT) && (mode_d == `CTCR_MODE_NORMAL);
      phy_rx_output_out    <= rx_d;
      rx_readback_q        <= phy_rx_output_out;
      wakeup_rx_readback_q <= wakeup_rx_in;
      mode_out             <= mode_d;
      split_bias_en_out    <= split_bias_enable_q && (mode_d == `CTCR_MODE_NORMAL);
      wakeup_rx_en_out     <= (wakeup_filter_select_q != `CTCR_WUP_OFF) &&
                              (mode_d != `CTCR_MODE_SHUTDOWN);
      slew_rate_out        <= slew_rate_select_q;
    end
  end

  // ----------------------------------------------------------------------------
  // Monitors, flags and interrupt
  // ----------------------------------------------------------------------------
  // Each monitor change, and each over-current pulse, sets a flag.
  always @* begin
    set_vec = `CTCR_ZERO8;
    set_vec[7:3] = status_q ^ status_prev_q;
    set_vec[`CTCR_IF_OC_HI:0] = over_current_in;
    clr_vec = wr_if ? wdata_in : `CTCR_ZERO8;
    // A set in the same cycle as its clear wins, so no event is lost.
    irq_flags_d = ((irq_flags_q & ~clr_vec) | set_vec) & `CTCR_FLAGS_MASK;
    en_vec = `CTCR_ZERO8;
    en_vec[7:4] = {4{irq_enable_q[`CTCR_IE_VF_BIT]}};
    en_vec[3] = irq_enable_q[`CTCR_IE_DT_BIT];
    en_vec[`CTCR_IF_OC_HI:0] = {2{irq_enable_q[`CTCR_IE_OC_BIT]}};
  end

  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      status_q      <= 5'h00;
      status_prev_q <= 5'h00;
      status_seen_q <= 1'b0;
      irq_enable_q  <= `CTCR_ZERO8;
      irq_flags_q   <= `CTCR_ZERO8;
      irq_out       <= 1'b0;
    end else begin
      status_q      <= bus_status_in;
      // The first sample primes both stages, so leaving reset is not taken for a monitor change.
      status_prev_q <= status_seen_q ? status_q : bus_status_in;
      status_seen_q <= 1'b1;
      if (wr_ie) begin
        irq_enable_q <= wdata_in & `CTCR_ENABLE_MASK;
      end
      irq_flags_q <= irq_flags_d;
      irq_out     <= |(irq_flags_d & en_vec);
    end
  end

  // ----------------------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------------------
  // Unimplemented bits are built as zero so they always read back clear.
  always @* begin
    rdata_d = `CTCR_ZERO8;
    case (addr_in)
      `CTCR_OFS_PORT_DATA: begin
        rdata_d[`CTCR_PD_WAKE_BIT] = wakeup_rx_readback_q;
        rdata_d[`CTCR_PD_TX_BIT]   = tx_drive_bit_q;
        rdata_d[`CTCR_PD_RX_BIT]   = rx_readback_q;
      end
      `CTCR_OFS_PHY_CTRL: begin
        rdata_d[`CTCR_PC_EN_BIT]                     = phy_enable_once_q;
        rdata_d[`CTCR_PC_SPLIT_BIT]                  = split_bias_enable_q;
        rdata_d[`CTCR_PC_WUP_HI:`CTCR_PC_WUP_LO]     = wakeup_filter_select_q;
        rdata_d[`CTCR_PC_SLEW_HI:`CTCR_PC_SLEW_LO]   = slew_rate_select_q;
      end
      `CTCR_OFS_TEST_A:     rdata_d = test_a_out;
      `CTCR_OFS_BUS_STATUS: rdata_d[7:`CTCR_ST_FIRST_BIT] = status_q;
      `CTCR_OFS_TEST_B:     rdata_d = test_b_out;
      `CTCR_OFS_TEST_C:     rdata_d = test_c_out;
      `CTCR_OFS_IRQ_ENABLE: rdata_d = irq_enable_q;
      `CTCR_OFS_IRQ_FLAGS:  rdata_d = irq_flags_q;
      default:              rdata_d = `CTCR_ZERO8;
    endcase
  end

  // Read data stands only in the cycle after the strobe.
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_out <= `CTCR_ZERO8;
    end else begin
      rdata_out <= rd_in ? rdata_d : `CTCR_ZERO8;
    end
  end

endmodule // ctcr_regs

`default_nettype wire

// file: ctcr_monitor.sv
// Concurrent checks on the ports of the transceiver control bank.
`timescale 1ns/1ns
`default_nettype none
`include "ctcr_map.vh"
module ctcr_monitor (
  input wire logic       core_clk_in,             // Core clock.
  input wire logic       rst_n_in,                // Reset, active low.
  input wire logic [2:0] addr_in,                 // Register offset.
  input wire logic [7:0] wdata_in,                // Write data.
  input wire logic       wr_in,                   // Write strobe.
  input wire logic       rd_in,                   // Read strobe.
  input wire logic [7:0] rdata_out,               // Read data.
  input wire logic       controller_tx_output_in, // Controller transmit.
  input wire logic       tx_route_reg_in,         // Transmit routing.
  input wire logic       precision_rx_in,         // Precision receiver.
  input wire logic       reg_rpm_in,              // Regulator reduced mode.
  input wire logic       phy_tx_input_out,        // Transmit input.
  input wire logic       tx_dominant_out,         // Dominant drive.
  input wire logic       phy_rx_output_out,       // Receive output.
  input wire logic [1:0] mode_out,                // Operating mode.
  input wire logic [2:0] slew_rate_out,           // Slew rate.
  input wire logic       irq_out                  // Fault interrupt.
);
  // ----------------------------------------------------------------
  // Properties, all in the core clock domain.
  // ----------------------------------------------------------------
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  chk_rdata_idle: assert property (!rd_in |=> rdata_out == 8'h00)
    else $error("read data not zero outside a read answer");
  chk_port_unused: assert property (rd_in && addr_in == 3'h0 |=> rdata_out[6:2] == 5'h00)
    else $error("unimplemented port data bits not zero");
  chk_slew_legal: assert property (slew_rate_out != 3'h3 && slew_rate_out != 3'h7)
    else $error("reserved slew code taken");
  chk_enable_sticky: assert property (mode_out != 2'h0 |=> mode_out != 2'h0 && mode_out != 2'h3)
    else $error("left enabled state");
  chk_enable_mode: assert property (wr_in && addr_in == 3'h1 && wdata_in[7] && !reg_rpm_in ##1 !reg_rpm_in
    |=> mode_out == `CTCR_MODE_NORMAL)
    else $error("enable did not give normal mode");
  chk_standby_entry: assert property (mode_out != 2'h0 && reg_rpm_in |=> mode_out == `CTCR_MODE_STANDBY)
    else $error("no standby under reduced regulator");
  chk_shutdown_quiet: assert property (mode_out == 2'h0 |-> phy_rx_output_out && !tx_dominant_out)
    else $error("shutdown not quiet");
  chk_rx_precision: assert property (mode_out == 2'h1 && $past(mode_out) == 2'h1
    |-> phy_rx_output_out == $past(precision_rx_in))
    else $error("receive output not from precision receiver");
  chk_tx_controller: assert property (!tx_route_reg_in |=> phy_tx_input_out == $past(controller_tx_output_in))
    else $error("transmit input not from controller");
  chk_tx_portbit: assert property (tx_route_reg_in && wr_in && addr_in == 3'h0 ##1 tx_route_reg_in
    |=> phy_tx_input_out == $past(wdata_in[1], 2))
    else $error("transmit input not from port data bit");
  cov_standby: cover property (mode_out == `CTCR_MODE_STANDBY);
  cov_irq: cover property (irq_out);
  cov_routed: cover property (tx_route_reg_in && wr_in && addr_in == 3'h0);
endmodule // ctcr_monitor
bind ctcr_regs ctcr_monitor i_mon (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
  .controller_tx_output_in(controller_tx_output_in), .tx_route_reg_in(tx_route_reg_in),
  .precision_rx_in(precision_rx_in), .reg_rpm_in(reg_rpm_in), .phy_tx_input_out(phy_tx_input_out),
  .tx_dominant_out(tx_dominant_out), .phy_rx_output_out(phy_rx_output_out), .mode_out(mode_out),
  .slew_rate_out(slew_rate_out), .irq_out(irq_out));
`default_nettype wire

// file: ctcr_ctl_model.sv
// Behavioural model of the protocol controller that drives transmit and samples receive.
`timescale 1ns/1ns
`default_nettype none
module ctcr_ctl_model (
  input  wire logic core_clk_in,       // Core clock.
  input  wire logic rst_n_in,          // Reset, active low.
  input  wire logic tx_level_in,       // Level asked of the controller, 1 recessive.
  input  wire logic phy_rx_output_in,  // Receive level from the transceiver.
  output var  logic ctl_tx_out,        // Transmit level toward the transceiver.
  output var  logic rx_seen_out        // Last sampled receive level.
);
  // ----------------------------------------------------------------
  // Idles recessive out of reset so the bus is never pulled by accident.
  // ----------------------------------------------------------------
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctl_tx_out <= 1'b1;
      rx_seen_out <= 1'b1;
    end else begin
      ctl_tx_out <= tx_level_in;
      rx_seen_out <= phy_rx_output_in;
    end
  end
endmodule // ctcr_ctl_model
`default_nettype wire

// file: tb_top.sv
// Self-checking testbench of the transceiver control bank.
`timescale 1ns/1ns
`default_nettype none
`include "ctcr_map.vh"
module tb_top;
  logic       core_clk_in = 1'b0;
  logic       rst_n_in = 1'b0;
  logic [2:0] addr_in = 3'h0;
  logic [7:0] wdata_in = 8'h00;
  logic       wr_in = 1'b0, rd_in = 1'b0, tx_level = 1'b1, route = 1'b0, prec_rx = 1'b1, wake_rx = 1'b1;
  logic       stop_req = 1'b0, rpm = 1'b0, special = 1'b0;
  logic [4:0] bus_st = 5'h15;
  logic [1:0] oc = 2'h0;
  wire  [7:0] rdata, tb_a, tb_b, tb_c;
  wire  [2:0] slew;
  wire  [1:0] mode;
  wire        ptx, tdom, prx, split, wen, irq, ctl_tx, rx_seen;
  int         miscompares = 0, samples_checked = 0, k;
  logic [2:0] exp_slew;
  always #4 core_clk_in = ~core_clk_in;
  ctcr_regs i_dut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata), .controller_tx_output_in(ctl_tx), .tx_route_reg_in(route),
    .precision_rx_in(prec_rx), .wakeup_rx_in(wake_rx), .stop_req_in(stop_req), .reg_rpm_in(rpm),
    .special_mode_in(special), .bus_status_in(bus_st), .over_current_in(oc), .phy_tx_input_out(ptx),
    .tx_dominant_out(tdom), .phy_rx_output_out(prx), .mode_out(mode), .split_bias_en_out(split),
    .wakeup_rx_en_out(wen), .slew_rate_out(slew), .test_a_out(tb_a), .test_b_out(tb_b),
    .test_c_out(tb_c), .irq_out(irq));
  ctcr_ctl_model i_ctl (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .tx_level_in(tx_level),
    .phy_rx_output_in(prx), .ctl_tx_out(ctl_tx), .rx_seen_out(rx_seen));
  // ----------------------------------------------------------------
  // Bus tasks; strobes last one cycle, read data is taken in the next.
  // ----------------------------------------------------------------
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge core_clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge core_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge core_clk_in);
    rd_in <= 1'b0;
    #1;
    chk8(rdata, exp);
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Watchdog: a hang counts as a mismatch and still reaches the verdict.
  initial begin
    #200000;
    miscompares++;
    close_out();
  end
  // ----------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    rd(3'h1, 8'h20);
    rd(3'h0, 8'h83);
    wake_rx <= 1'b0;
    cyc(3);
    rd(3'h0, 8'h03);
    $display("reset values done");
    wr(3'h2, 8'hA5);
    rd(3'h2, 8'h00);
    chk8(tb_a, 8'h00);
    special <= 1'b1;
    wr(3'h4, 8'h5A);
    wr(3'h5, 8'h3C);
    special <= 1'b0;
    wr(3'h4, 8'h00);
    wr(3'h5, 8'h00);
    rd(3'h4, 8'h5A);
    chk8(tb_b, 8'h5A);
    chk8(tb_c, 8'h3C);
    wr(3'h3, 8'hFF);
    rd(3'h3, 8'hA8);
    $display("factory and status done");
    exp_slew = 3'h0;
    for (k = 0; k < 8; k++) begin
      wr(3'h1, {5'h04, 3'(k)});
      if (k != 3 && k != 7) exp_slew = 3'(k);
      rd(3'h1, {5'h04, exp_slew});
      chk8({5'h00, slew}, {5'h00, exp_slew});
    end
    for (k = 0; k < 4; k++) begin
      wr(3'h1, {2'h0, 2'(k), 4'h0});
      rd(3'h1, {2'h0, 2'(k), 4'h0});
      chk8({7'h00, wen}, 8'h00);
    end
    $display("slew and wake select done");
    wr(3'h1, 8'hC2);
    cyc(2);
    chk8({6'h00, mode}, {6'h00, `CTCR_MODE_NORMAL});
    chk8({6'h00, split, wen}, 8'h02);
    wr(3'h1, 8'h22);
    cyc(2);
    rd(3'h1, 8'hA2);
    chk8({6'h00, split, wen}, 8'h01);
    $display("enable done");
    prec_rx <= 1'b0;
    cyc(3);
    chk8({6'h00, prx, rx_seen}, 8'h00);
    rd(3'h0, 8'h02);
    tx_level <= 1'b0;
    cyc(3);
    chk8({6'h00, ptx, tdom}, 8'h01);
    tx_level <= 1'b1;
    route <= 1'b1;
    wr(3'h0, 8'hFD);
    cyc(2);
    chk8({7'h00, ptx}, 8'h00);
    rd(3'h0, 8'h00);
    wr(3'h0, 8'h02);
    cyc(2);
    chk8({7'h00, ptx}, 8'h01);
    route <= 1'b0;
    prec_rx <= 1'b1;
    $display("link done");
    wr(3'h7, 8'hFF);
    rd(3'h7, 8'h00);
    wr(3'h6, 8'hFF);
    rd(3'h6, 8'h19);
    oc <= 2'h1;
    cyc(1);
    oc <= 2'h0;
    cyc(2);
    chk8({7'h00, irq}, 8'h01);
    rd(3'h7, 8'h01);
    wr(3'h6, 8'h18);
    cyc(2);
    chk8({7'h00, irq}, 8'h00);
    wr(3'h7, 8'h01);
    bus_st <= 5'h14;
    cyc(5);
    rd(3'h7, 8'h08);
    chk8({7'h00, irq}, 8'h01);
    wr(3'h7, 8'h08);
    cyc(2);
    chk8({7'h00, irq}, 8'h00);
    $display("interrupt done");
    wake_rx <= 1'b1;
    rpm <= 1'b1;
    cyc(3);
    chk8({6'h00, mode}, {6'h00, `CTCR_MODE_STANDBY});
    wake_rx <= 1'b0;
    cyc(4);
    chk8({7'h00, prx}, 8'h00);
    wake_rx <= 1'b1;
    wr(3'h1, 8'h12);
    stop_req <= 1'b1;
    cyc(4);
    wake_rx <= 1'b0;
    cyc(4);
    chk8({7'h00, prx}, 8'h01);
    wake_rx <= 1'b1;
    cyc(4);
    wake_rx <= 1'b0;
    for (k = 0; k < 10 && prx !== 1'b0; k++) cyc(1);
    chk8({7'h00, prx}, 8'h00);
    wake_rx <= 1'b1;
    stop_req <= 1'b0;
    wr(3'h1, 8'h32);
    stop_req <= 1'b1;
    for (k = 0; k < 2; k++) begin
      wake_rx <= 1'b0;
      cyc(3);
      chk8({7'h00, prx}, 8'h01);
      wake_rx <= 1'b1;
      cyc(3);
    end
    wake_rx <= 1'b0;
    cyc(3);
    chk8({7'h00, prx}, 8'h00);
    wr(3'h1, 8'h02);
    cyc(2);
    chk8({7'h00, wen}, 8'h00);
    $display("standby filter done");
    close_out();
  end
endmodule // tb_top
`default_nettype wire
